/* File: design/gwt_timer.v */
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "gwt_defs.vh"
//
// Contract
// R1 - start write sets enable status
// R2 - start and stop bits self-clear
// R3 - stop write clears enable, halts counter
// R4 - stopped counter keeps its value
// R5 - pin edges ignored while stopped
// R6 - period mode restart counts from zero
// R7 - gate mode: start edge loads all ones
// R8 - stop edge holds; next start resumes
// R9 - zero reached: interrupt, reload, continue
// R10 - software writes all ones to compare
// R11 - code 10 measures low time
// R12 - code 11 measures high time
// R13 - software never restarts running gate mode
// R14 - clock select picks one of four
// R15 - software sets count clock select 00
// R16 - software writes gate mode 1100
// R17 - software writes trigger source 010
// R18 - software clears start interrupt bit
// R19 - software zeroes overflow control, main/sub
// R20 - software keeps rewrite bits zero
// R21 - output pin not driven by counting
// R22 - counter readable any time
// R23 - pin sampled on operating clock edges
//
module gwt_timer (
    input wire CORE_CLK_I,
    input wire ARST_N_I,
    input wire [3:0] PRESCALED_TICK_I,
    input wire TRIGGER_INPUT_PIN_I,
    input wire DIRECT_OUT_LEVEL_I,
    input wire [7:0] S_AXI_AWADDR_I,
    input wire S_AXI_AWVALID_I,
    output reg S_AXI_AWREADY_O,
    input wire [31:0] S_AXI_WDATA_I,
    input wire [3:0] S_AXI_WSTRB_I,
    input wire S_AXI_WVALID_I,
    output reg S_AXI_WREADY_O,
    output reg [1:0] S_AXI_BRESP_O,
    output reg S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    input wire [7:0] S_AXI_ARADDR_I,
    input wire S_AXI_ARVALID_I,
    output reg S_AXI_ARREADY_O,
    output reg [31:0] S_AXI_RDATA_O,
    output reg [1:0] S_AXI_RRESP_O,
    output reg S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    output reg CHANNEL_INTERRUPT_O,
    output reg CHANNEL_OUTPUT_PIN_O
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [15:0] mode_r; // channel_mode_control
    reg [1:0] edge_sel_r; // edge_select_field
    reg [31:0] cdr_r; // compare_data_register
    reg [31:0] cnt_r; // channel_counter
    reg enable_r; // enable_status_bit
    reg gate_open_r; // gate currently counting
    reg started_r; // first start edge seen since enable
    reg [31:0] irq_count_r; // count of gate-mode zero-reload interrupts, for software; period-mode stop interrupts are not counted
    reg [7:0] aw_addr_r; // latched write address
    reg aw_have_r; // write address held
    reg [31:0] w_data_r; // latched write data
    reg [3:0] w_strb_r; // latched strobes
    reg w_have_r; // write data held
    wire tick; // operating clock tick
    wire rise; // sampled rising edge
    wire fall; // sampled falling edge
    wire [3:0] md; // operating_mode_field
    wire gate_mode; // gated width mode selected
    wire period_mode; // period measurement mode selected
    wire start_edge; // gate opening edge
    wire stop_edge; // gate closing edge
    wire wr_fire; // write commits this cycle
    wire start_wr; // start_trigger_bit written as 1
    wire stop_wr; // stop_trigger_bit written as 1

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    assign md = mode_r[`GWT_MD_HI:`GWT_MD_LO];
    assign gate_mode = (md == `GWT_MD_GATE);
    assign period_mode = (md == `GWT_MD_PERIOD);

    // registered select: a clock-select change never yields a half tick
    gwt_clk_sel u_clk_sel (
        .CLK_I(CORE_CLK_I),
        .ARST_N_I(ARST_N_I),
        .TICKS_I(PRESCALED_TICK_I),
        .SEL_I(mode_r[`GWT_CKS_HI:`GWT_CKS_LO]),
        .TICK_O(tick)
    );

    // pin seen only on the selected tick, so pulses shorter than a tick may be lost
    gwt_edge_detect u_edge (
        .CLK_I(CORE_CLK_I),
        .ARST_N_I(ARST_N_I),
        .TICK_I(tick),
        .PIN_I(TRIGGER_INPUT_PIN_I),
        .RISE_O(rise),
        .FALL_O(fall)
    );

    // ----------------------------------------
    // gate edge routing
    // ----------------------------------------
    // high time: rise opens, fall closes; low time: the reverse
    assign start_edge = (edge_sel_r == `GWT_TIS_HIGH) ? rise :   // [R12]
                        (edge_sel_r == `GWT_TIS_LOW) ? fall : 1'b0;  // [R11]
    assign stop_edge = (edge_sel_r == `GWT_TIS_HIGH) ? fall :    // [R12]
                       (edge_sel_r == `GWT_TIS_LOW) ? rise : 1'b0;   // [R11]

    // ----------------------------------------
    // axi4-lite write path
    // ----------------------------------------
    assign wr_fire = aw_have_r & w_have_r & ~S_AXI_BVALID_O;
    // trigger register holds nothing: writes only pulse [R2]
    assign start_wr = wr_fire & (aw_addr_r == `GWT_OFF_TRIG) & w_strb_r[0] &
                      w_data_r[`GWT_BIT_START];
    assign stop_wr = wr_fire & (aw_addr_r == `GWT_OFF_TRIG) & w_strb_r[0] &
                     w_data_r[`GWT_BIT_STOP];

    // address and data are accepted independently, response after both
    always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= `GWT_RESP_OKAY;
            aw_addr_r <= 8'h00;
            aw_have_r <= 1'b0;
            w_data_r <= `GWT_ZERO;
            w_strb_r <= 4'h0;
            w_have_r <= 1'b0;
        end else begin
            S_AXI_AWREADY_O <= ~aw_have_r & ~S_AXI_AWREADY_O & S_AXI_AWVALID_I;
            S_AXI_WREADY_O <= ~w_have_r & ~S_AXI_WREADY_O & S_AXI_WVALID_I;
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_addr_r <= S_AXI_AWADDR_I;
                aw_have_r <= 1'b1;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_data_r <= S_AXI_WDATA_I;
                w_strb_r <= S_AXI_WSTRB_I;
                w_have_r <= 1'b1;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                // counter and status are read-only; unmapped gets slverr
                case (aw_addr_r)
                    `GWT_OFF_TRIG, `GWT_OFF_MODE, `GWT_OFF_EDGE, `GWT_OFF_CDR: begin
                        S_AXI_BRESP_O <= `GWT_RESP_OKAY;
                    end
                    `GWT_OFF_STAT, `GWT_OFF_CNT, `GWT_OFF_IRQ: begin
                        S_AXI_BRESP_O <= `GWT_RESP_OKAY;
                    end
                    default: begin
                        S_AXI_BRESP_O <= `GWT_RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mode_r <= `GWT_MODE_RST;
            edge_sel_r <= `GWT_EDGE_RST;
            cdr_r <= `GWT_CDR_RST;
        end else if (wr_fire) begin
            if (aw_addr_r == `GWT_OFF_MODE) begin
                if (w_strb_r[0]) mode_r[7:0] <= w_data_r[7:0];
                if (w_strb_r[1]) mode_r[15:8] <= w_data_r[15:8];
            end
            if (aw_addr_r == `GWT_OFF_EDGE && w_strb_r[0]) begin
                edge_sel_r <= w_data_r[1:0];
            end
            if (aw_addr_r == `GWT_OFF_CDR) begin
                if (w_strb_r[0]) cdr_r[7:0] <= w_data_r[7:0];
                if (w_strb_r[1]) cdr_r[15:8] <= w_data_r[15:8];
                if (w_strb_r[2]) cdr_r[23:16] <= w_data_r[23:16];
                if (w_strb_r[3]) cdr_r[31:24] <= w_data_r[31:24];
            end
        end
    end

    // ----------------------------------------
    // channel counting
    // ----------------------------------------
    always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            enable_r <= 1'b0;
            gate_open_r <= 1'b0;
            started_r <= 1'b0;
            cnt_r <= `GWT_CNT_RST;
            irq_count_r <= `GWT_ZERO;
            CHANNEL_INTERRUPT_O <= 1'b0;
        end else begin
            CHANNEL_INTERRUPT_O <= 1'b0;
            if (stop_wr) begin
                // stop wins over a simultaneous start; value kept [R3] [R4]
                enable_r <= 1'b0;
                gate_open_r <= 1'b0;
            end else if (start_wr) begin
                enable_r <= 1'b1; // [R1]
                gate_open_r <= 1'b0;
                started_r <= 1'b0;
                if (period_mode) begin
                    cnt_r <= `GWT_ZERO; // restart from zero [R6]
                end
            end else if (enable_r) begin
                // edges reach here only while enabled [R5]
                if (gate_mode) begin
                    if (start_edge && !gate_open_r) begin
                        gate_open_r <= 1'b1;
                        started_r <= 1'b1;
                        if (!started_r) begin
                            cnt_r <= cdr_r; // first start loads cdr_r, set to all ones by software [R7] [R10]
                        end
                        // later starts resume from held value [R8]
                    end else if (stop_edge && gate_open_r) begin
                        gate_open_r <= 1'b0; // hold value [R8]
                    end else if (gate_open_r && tick) begin
                        if (cnt_r == `GWT_ZERO) begin
                            CHANNEL_INTERRUPT_O <= 1'b1; // [R9]
                            irq_count_r <= irq_count_r + `GWT_ONE;
                            cnt_r <= cdr_r; // reload and keep going [R9]
                        end else begin
                            cnt_r <= cnt_r - `GWT_ONE;
                        end
                    end
                end else if (period_mode) begin
                    // simplified up-count while gate is open
                    if (start_edge) begin
                        gate_open_r <= 1'b1;
                    end else if (stop_edge) begin
                        gate_open_r <= 1'b0;
                        CHANNEL_INTERRUPT_O <= 1'b1;
                    end else if (gate_open_r && tick) begin
                        cnt_r <= cnt_r + `GWT_ONE;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // output pin always follows the direct level
    // ----------------------------------------
    always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CHANNEL_OUTPUT_PIN_O <= 1'b0;
        end else begin
            CHANNEL_OUTPUT_PIN_O <= DIRECT_OUT_LEVEL_I; // not from counting [R21]
        end
    end

    // ----------------------------------------
    // axi4-lite read path
    // ----------------------------------------
    always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= `GWT_ZERO;
            S_AXI_RRESP_O <= `GWT_RESP_OKAY;
        end else begin
            // reads have no side effect, so software may poll the counter mid-count
            S_AXI_ARREADY_O <= ~S_AXI_ARREADY_O & ~S_AXI_RVALID_O & S_AXI_ARVALID_I;
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RRESP_O <= `GWT_RESP_OKAY;
                case (S_AXI_ARADDR_I)
                    `GWT_OFF_TRIG: S_AXI_RDATA_O <= `GWT_ZERO; // triggers read 0 [R2]
                    `GWT_OFF_STAT: S_AXI_RDATA_O <= {29'h000_0000, started_r,
                                                     gate_open_r, enable_r};
                    `GWT_OFF_MODE: S_AXI_RDATA_O <= {16'h0000, mode_r};
                    `GWT_OFF_EDGE: S_AXI_RDATA_O <= {30'h000_0000, edge_sel_r};
                    `GWT_OFF_CDR: S_AXI_RDATA_O <= cdr_r;
                    `GWT_OFF_CNT: S_AXI_RDATA_O <= cnt_r; // no side effect [R22]
                    `GWT_OFF_IRQ: S_AXI_RDATA_O <= irq_count_r;
                    default: begin
                        S_AXI_RDATA_O <= `GWT_ZERO;
                        S_AXI_RRESP_O <= `GWT_RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end
endmodule

/* File: design/gwt_defs.vh */
`ifndef GWT_DEFS_VH
`define GWT_DEFS_VH
// register byte offsets
`define GWT_OFF_TRIG 8'h00
`define GWT_OFF_STAT 8'h04
`define GWT_OFF_MODE 8'h08
`define GWT_OFF_EDGE 8'h0C
`define GWT_OFF_CDR 8'h10
`define GWT_OFF_CNT 8'h14
`define GWT_OFF_IRQ 8'h18
// trigger register bits
`define GWT_BIT_START 0
`define GWT_BIT_STOP 1
// mode register fields
`define GWT_MODE_W 16
`define GWT_CKS_HI 15
`define GWT_CKS_LO 14
`define GWT_MD_HI 4
`define GWT_MD_LO 1
`define GWT_MD_GATE 4'b1100
`define GWT_MD_PERIOD 4'b1101
`define GWT_TIS_LOW 2'b10
`define GWT_TIS_HIGH 2'b11
// reset values
`define GWT_MODE_RST 16'h0000
`define GWT_EDGE_RST 2'b00
`define GWT_CDR_RST 32'hFFFF_FFFF
`define GWT_CNT_RST 32'h0000_0000
`define GWT_ALL_ONES 32'hFFFF_FFFF
`define GWT_ZERO 32'h0000_0000
`define GWT_ONE 32'h0000_0001
// axi responses
`define GWT_RESP_OKAY 2'b00
`define GWT_RESP_SLVERR 2'b10
`endif

/* File: design/gwt_edge_detect.v */
`timescale 1ns/100ps
`include "gwt_defs.vh"
// samples the gate pin on the operating tick and flags edges
module gwt_edge_detect (
    input wire CLK_I,
    input wire ARST_N_I,
    input wire TICK_I,
    input wire PIN_I,
    output reg RISE_O,
    output reg FALL_O
);
    reg samp_r; // current sample
    reg prev_r; // previous sample
    // ----------------------------------------
    // sample and compare successive values
    // ----------------------------------------
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            samp_r <= 1'b0;
            prev_r <= 1'b0;
            RISE_O <= 1'b0;
            FALL_O <= 1'b0;
        end else begin
            RISE_O <= 1'b0;
            FALL_O <= 1'b0;
            if (TICK_I) begin
                // edges only seen at operating clock rate [R23]
                samp_r <= PIN_I;
                prev_r <= samp_r;
                RISE_O <= samp_r & ~prev_r;
                FALL_O <= ~samp_r & prev_r;
            end
        end
    end
endmodule

/* File: design/gwt_clk_sel.v */
`timescale 1ns/100ps
`include "gwt_defs.vh"
// picks one of four prescaled tick enables
module gwt_clk_sel (
    input wire CLK_I,
    input wire ARST_N_I,
    input wire [3:0] TICKS_I,
    input wire [1:0] SEL_I,
    output reg TICK_O
);
    // ----------------------------------------
    // registered mux keeps the tick glitch-free
    // ----------------------------------------
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            TICK_O <= 1'b0;
        end else begin
            TICK_O <= TICKS_I[SEL_I]; // code n picks clock n [R14]
        end
    end
endmodule

/* File: tb/gwt_gate_source.sv */
`timescale 1ns/100ps
// ----------------------------------------
// gate pin source: the external party
// ----------------------------------------
module gwt_gate_source (
    input wire clk_i,
    input wire level_i,
    output logic pin_o = 1'b0
);
    // level moves just after an edge, so the design samples a clean, settled pin
    // starts low, the idle level the edge detector resets to
    // registered copy; both gate edges share the same one-cycle lag
    always @(posedge clk_i) begin
        pin_o <= level_i;
    end
endmodule

/* File: tb/gwt_timer_properties.sv */
`timescale 1ns/100ps
`include "gwt_defs.vh"
// ----------------------------------------
// port-level checker for the timer
// ----------------------------------------
module gwt_timer_properties (
    input wire CORE_CLK_I,
    input wire ARST_N_I,
    input wire DIRECT_OUT_LEVEL_I,
    input wire [7:0] S_AXI_ARADDR_I,
    input wire S_AXI_ARVALID_I,
    input wire S_AXI_ARREADY_O,
    input wire [31:0] S_AXI_RDATA_O,
    input wire [1:0] S_AXI_RRESP_O,
    input wire S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    input wire S_AXI_AWREADY_O,
    input wire [1:0] S_AXI_BRESP_O,
    input wire S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    input wire CHANNEL_INTERRUPT_O,
    input wire CHANNEL_OUTPUT_PIN_O
);
    // one domain, so clock and reset are stated once
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!ARST_N_I);
    // address ready is a single-cycle pulse
    aw_pulse_a: assert property (S_AXI_AWREADY_O |=> !S_AXI_AWREADY_O)
        else $error("write address ready held too long");
    // write response stands until taken
    bvalid_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
        |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped early");
    // read data stands until taken
    rvalid_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
        |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data dropped early");
    // read answer follows acceptance by one edge
    read_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read answer late");
    // reads above the last offset give an error and zero data
    bad_read_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I > 8'h18
        |=> S_AXI_RRESP_O == `GWT_RESP_SLVERR && S_AXI_RDATA_O == 32'h0000_0000)
        else $error("unmapped read not refused");
    // trigger bits never read back as set
    trig_zero_a: assert property (
        S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == `GWT_OFF_TRIG
        |=> S_AXI_RDATA_O == 32'h0000_0000)
        else $error("trigger bits read back set");
    // interrupt is a one-cycle pulse
    irq_pulse_a: assert property (CHANNEL_INTERRUPT_O |=> !CHANNEL_INTERRUPT_O)
        else $error("interrupt longer than one cycle");
    // output pin only mirrors the direct level, never the count
    out_pin_a: assert property ($past(ARST_N_I)
        |-> CHANNEL_OUTPUT_PIN_O == $past(DIRECT_OUT_LEVEL_I))
        else $error("output pin not the direct level");
endmodule

/* File: tb/gwt_timer_bench.sv */
`timescale 1ns/100ps
`include "gwt_defs.vh"
module gwt_timer_bench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] tcnt = 3'h0;  // free count for the four tick rates
    wire [3:0] ticks = {tcnt == 3'h0, tcnt[1:0] == 2'h0, !tcnt[0], 1'b1};
    logic lvl = 1'b0;  // requested gate level
    wire pin;
    logic dout = 1'b0;
    logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
    logic [31:0] w_data = 32'h0000_0000;
    logic aw_vld = 1'b0, w_vld = 1'b0, b_rdy = 1'b0, ar_vld = 1'b0, r_rdy = 1'b0;
    wire aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq, out_pin;
    wire [1:0] b_resp, r_resp;
    wire [31:0] r_data;
    logic [31:0] rd, base;  // last read data, reference count
    logic [1:0] rs, bs;  // last read and write responses
    int n_mismatch = 0, checks_done = 0, n_irq = 0, n0, k, e;
    // ----------------------------------------
    // clock, ticks, interrupt count
    // ----------------------------------------
    always #20 clk = ~clk;
    always @(posedge clk) begin
        tcnt <= tcnt + 3'h1;
        if (irq === 1'b1) n_irq <= n_irq + 1;  // pulses seen at the port
    end
    gwt_gate_source u_src (.clk_i(clk), .level_i(lvl), .pin_o(pin));
    gwt_timer u_dut (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .PRESCALED_TICK_I(ticks),
        .TRIGGER_INPUT_PIN_I(pin), .DIRECT_OUT_LEVEL_I(dout),
        .S_AXI_AWADDR_I(aw_addr), .S_AXI_AWVALID_I(aw_vld), .S_AXI_AWREADY_O(aw_rdy),
        .S_AXI_WDATA_I(w_data), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(w_vld),
        .S_AXI_WREADY_O(w_rdy), .S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_vld),
        .S_AXI_BREADY_I(b_rdy), .S_AXI_ARADDR_I(ar_addr), .S_AXI_ARVALID_I(ar_vld),
        .S_AXI_ARREADY_O(ar_rdy), .S_AXI_RDATA_O(r_data), .S_AXI_RRESP_O(r_resp),
        .S_AXI_RVALID_O(r_vld), .S_AXI_RREADY_I(r_rdy), .CHANNEL_INTERRUPT_O(irq),
        .CHANNEL_OUTPUT_PIN_O(out_pin));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // both channels offered together; bready stays up until the response lands
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        aw_addr <= a;
        w_data <= d;
        aw_vld <= 1'b1;
        w_vld <= 1'b1;
        b_rdy <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_rdy === 1'b1) aw_vld <= 1'b0;
            if (w_rdy === 1'b1) w_vld <= 1'b0;
        end while (b_vld !== 1'b1);
        bs = b_resp;
        b_rdy <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        ar_addr <= a;
        ar_vld <= 1'b1;
        r_rdy <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_rdy === 1'b1) ar_vld <= 1'b0;
        end while (r_vld !== 1'b1);
        rd = r_data;
        rs = r_resp;
        r_rdy <= 1'b0;
    endtask
    // gate open for n cycles, then closed for 16
    task automatic pulse(input int n, input logic open);
        lvl <= open;
        repeat (n) @(posedge clk);
        lvl <= !open;
        repeat (16) @(posedge clk);
    endtask
    task automatic complete_run;
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // a hang is cut short well past the expected run of under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        complete_run;
    end
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`GWT_OFF_CDR);
        check(rd, `GWT_CDR_RST);
        rd_reg(8'h1C);
        check({30'h0, rs}, {30'h0, `GWT_RESP_SLVERR});
        wr(8'h1C, 32'h0000_0001);
        check({30'h0, bs}, {30'h0, `GWT_RESP_SLVERR});
        wr(`GWT_OFF_CDR, `GWT_ALL_ONES);
        check({30'h0, bs}, {30'h0, `GWT_RESP_OKAY});
        // every clock select, high-time gate, two openings without reload
        for (k = 0; k < 4; k++) begin
            wr(`GWT_OFF_TRIG, 32'h0000_0002);
            // ccs, mas, cos, md0 zero, trigger source 010, no rewrite
            wr(`GWT_OFF_MODE, {16'h0000, k[1:0], 9'h010, `GWT_MD_GATE, 1'b0});
            wr(`GWT_OFF_EDGE, {30'h0, `GWT_TIS_HIGH});
            wr(`GWT_OFF_TRIG, 32'h0000_0001);
            rd_reg(`GWT_OFF_STAT);
            check({31'h0, rd[0]}, 32'h0000_0001);
            rd_reg(`GWT_OFF_TRIG);
            check(rd, 32'h0000_0000);
            pulse(32, 1'b1);
            pulse(32, 1'b1);
            rd_reg(`GWT_OFF_CNT);
            base = ~rd;
            e = 64 >> k;  // ticks seen while open, loaded from all ones
            check({31'h0, base + 4 >= e && base <= e + 2}, 32'h1);
            repeat (20) @(posedge clk);
            rd_reg(`GWT_OFF_CNT);
            check(~rd, base);
        end
        // stopped: count kept, pin edges ignored
        wr(`GWT_OFF_TRIG, 32'h0000_0002);
        rd_reg(`GWT_OFF_STAT);
        check({31'h0, rd[0]}, 32'h0000_0000);
        rd_reg(`GWT_OFF_CNT);
        base = rd;
        pulse(32, 1'b1);
        rd_reg(`GWT_OFF_CNT);
        check(rd, base);
        // period mode restart begins from zero
        wr(`GWT_OFF_MODE, {16'h0000, 2'b00, 9'h000, `GWT_MD_PERIOD, 1'b0});
        wr(`GWT_OFF_TRIG, 32'h0000_0001);
        rd_reg(`GWT_OFF_CNT);
        check(rd, `GWT_ZERO);
        // low-time gate with a short compare, so the zero crossing is reachable
        wr(`GWT_OFF_TRIG, 32'h0000_0002);
        wr(`GWT_OFF_CDR, 32'h0000_0008);
        wr(`GWT_OFF_MODE, {16'h0000, 2'b00, 9'h000, `GWT_MD_GATE, 1'b0});
        wr(`GWT_OFF_EDGE, {30'h0, `GWT_TIS_LOW});
        lvl <= 1'b1;
        wr(`GWT_OFF_TRIG, 32'h0000_0001);
        repeat (20) @(posedge clk);
        rd_reg(`GWT_OFF_CNT);
        check(rd, `GWT_ZERO);
        n0 = n_irq;
        dout <= 1'b1;
        pulse(40, 1'b0);
        check({31'h0, n_irq - n0 >= 3 && n_irq - n0 <= 5}, 32'h1);
        rd_reg(`GWT_OFF_CNT);
        check({31'h0, rd <= 32'h0000_0008}, 32'h1);
        check({31'h0, out_pin}, 32'h1);
        rd_reg(`GWT_OFF_IRQ);
        check(rd, n_irq);
        complete_run;
    end
endmodule
bind gwt_timer gwt_timer_properties u_props (.CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I),
    .DIRECT_OUT_LEVEL_I(DIRECT_OUT_LEVEL_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
    .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
    .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
    .CHANNEL_INTERRUPT_O(CHANNEL_INTERRUPT_O), .CHANNEL_OUTPUT_PIN_O(CHANNEL_OUTPUT_PIN_O));
